// ---- rtl/ssd_axis_ctrl.v ----
// Behaviour
// (RULE_01) one step per rising step edge while the gate input is inactive
// (RULE_02) direction inactive steps clockwise, active steps counterclockwise
// (RULE_03) in gate mode an active gate input blocks all step pulses
// (RULE_04) in enable mode readiness follows about 100 ms after enable goes active
// (RULE_05) enable inactive: no readiness, overvoltage and undervoltage lit, ring held
// (RULE_06) latched faults clear on reset or enable off then on, cause gone
// (RULE_07) fine input equal to microstep switch gives standard, otherwise microstep
// (RULE_08) controller times fine-resolution changes like the gate input
// (RULE_09) pwm current input scales phase current by its inactive fraction
// (RULE_10) active current input removes phase current, inactive applies full current
// (RULE_11) readiness output and indicator only while operating properly or enabled; the code requires both, fault-free and not disabled
// (RULE_12) short circuit between phase leads raises the short flag
// (RULE_13) heat sink overtemperature raises the overheat flag
// (RULE_14) supply above limit raises the overvoltage flag
// (RULE_15) supply below limit raises the undervoltage flag
// (RULE_16) excessive step rate raises all four fault flags together
// (RULE_17) any fault de-energizes the motor and drops readiness until cleared
// (RULE_18) steps per revolution 200/400/500/1000, ten times at microstep
// (RULE_19) selector off chooses enable mode, on chooses gate mode
// (RULE_20) all control inputs synchronised, step edges taken from synced level
// (RULE_21) ring counts up or down per direction, wrapping at its length
`timescale 1ns/10ps
`default_nettype none
`include "ssd_map.vh"

module ssd_axis_ctrl #(
    parameter READY_DELAY_CYC = `SSD_READY_DELAY_CYC
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // motion controller inputs, high = energized
    input wire step_in,
    input wire dir_in,
    input wire gate_en_in,
    input wire fine_res_in,
    input wire cur_ctrl_in,
    // power stage detectors, high = condition present
    input wire short_det,
    input wire overtemp_det,
    input wire overvolt_det,
    input wire undervolt_det,
    // readiness and indicators
    output wire ready_relay,
    output wire ready_led,
    output wire fault_led,
    output wire temp_led,
    output wire overv_led,
    output wire lowv_led,
    // power stage controls
    output wire phase_energize,
    output wire [3:0] phase_current_select,
    output wire current_reduction_switch,
    output wire [13:0] ring_pos
);

    // ****************************************************************
    // input synchronisation
    // ****************************************************************
    wire [8:0] sync_bus;

    // every control input is sampled through two flops
    ssd_sync #(
        .WIDTH(9)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({undervolt_det, overvolt_det, overtemp_det, short_det,
                   cur_ctrl_in, fine_res_in, gate_en_in, dir_in, step_in}),
        .sync_out(sync_bus)
    ); // RULE_20

    wire step_s = sync_bus[0];
    wire dir_s = sync_bus[1];
    wire gate_en_s = sync_bus[2];
    wire fine_s = sync_bus[3];
    wire cur_s = sync_bus[4];
    wire short_s = sync_bus[5];
    wire temp_s = sync_bus[6];
    wire overv_s = sync_bus[7];
    wire lowv_s = sync_bus[8];

    // ****************************************************************
    // state
    // ****************************************************************
    reg [11:0] ctrl_reg;
    reg step_prev_reg;
    reg en_prev_reg;
    reg [13:0] ring_reg;
    reg [13:0] ring_next;
    reg [31:0] ready_cnt_reg;
    reg ready_reg;
    reg energize_reg;
    reg flag_short_reg;
    reg flag_temp_reg;
    reg flag_overv_reg;
    reg flag_lowv_reg;
    reg rate_seen_reg;
    reg [15:0] gap_cnt_reg;
    reg fault_led_reg;
    reg temp_led_reg;
    reg overv_led_reg;
    reg lowv_led_reg;
    reg [31:0] prdata_reg;
    reg pready_reg;
    reg pslverr_reg;

    // ****************************************************************
    // switch decode
    // ****************************************************************
    wire gate_mode = ctrl_reg[`SSD_CTRL_GATE_SEL]; // RULE_19
    wire micro_sw = ctrl_reg[`SSD_CTRL_MICRO_SW];
    wire [1:0] step_sw = {ctrl_reg[`SSD_CTRL_STEP_SW1], ctrl_reg[`SSD_CTRL_STEP_SW2]};

    // standard when input level matches switch position
    wire micro_mode = fine_s ^ micro_sw; // RULE_07

    reg [13:0] steps_base;
    reg [13:0] steps_per_rev;

    // step switches pick the base count; microstep multiplies by ten
    always @* begin
        case (step_sw)
            2'b10: steps_base = `SSD_STEPS_200;
            2'b11: steps_base = `SSD_STEPS_400;
            2'b01: steps_base = `SSD_STEPS_500;
            default: steps_base = `SSD_STEPS_1000;
        endcase
        if (micro_mode) begin
            steps_per_rev = steps_base * `SSD_MICRO_FACTOR; // RULE_18
        end else begin
            steps_per_rev = steps_base; // RULE_18
        end
    end

    // ****************************************************************
    // enable, gate and fault summary
    // ****************************************************************
    wire enable_mode = ~gate_mode;
    wire disabled = enable_mode & ~gate_en_s;
    wire gated = gate_mode & gate_en_s;
    wire en_rise = enable_mode & gate_en_s & ~en_prev_reg;
    wire step_edge = step_s & ~step_prev_reg; // RULE_20
    wire any_fault = flag_short_reg | flag_temp_reg | flag_overv_reg | flag_lowv_reg;

    // too short a gap between accepted edges counts as interference
    wire rate_hit = step_edge & ~gated & (gap_cnt_reg < `SSD_MIN_STEP_CYC);

    // ****************************************************************
    // edge history
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_prev_reg <= 1'b0;
            en_prev_reg <= 1'b0;
        end else begin
            step_prev_reg <= step_s;
            en_prev_reg <= gate_en_s;
        end
    end

    // ****************************************************************
    // step rate watchdog
    // ****************************************************************
    // saturating gap counter, restarted by every accepted edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt_reg <= 16'hFFFF;
        end else if (step_edge & ~gated) begin
            gap_cnt_reg <= 16'h0000;
        end else if (gap_cnt_reg != 16'hFFFF) begin
            gap_cnt_reg <= gap_cnt_reg + 16'h0001;
        end
    end

    // ****************************************************************
    // setpoint ring counter
    // ****************************************************************
    // a ratio switch change may leave the ring above the new length,
    // so an out-of-range value goes to zero on an up step and to the last position on a down step
    always @* begin
        ring_next = ring_reg;
        if (dir_s) begin
            if (ring_reg == 14'h0000 || ring_reg >= steps_per_rev) begin
                ring_next = steps_per_rev - 14'h0001; // RULE_21
            end else begin
                ring_next = ring_reg - 14'h0001; // RULE_02
            end
        end else begin
            if (ring_reg >= steps_per_rev - 14'h0001) begin
                ring_next = 14'h0000; // RULE_21
            end else begin
                ring_next = ring_reg + 14'h0001; // RULE_02
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_reg <= 14'h0000;
        end else if (disabled) begin
            ring_reg <= 14'h0000; // RULE_05
        end else if (step_edge & ~gated) begin
            ring_reg <= ring_next; // RULE_01 RULE_03
        end
    end

    // ****************************************************************
    // latched fault flags
    // ****************************************************************
    // a live detector wins over the clear, so a flag only drops
    // once its cause is gone
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_short_reg <= 1'b0;
            flag_temp_reg <= 1'b0;
            flag_overv_reg <= 1'b0;
            flag_lowv_reg <= 1'b0;
            rate_seen_reg <= 1'b0;
        end else begin
            flag_short_reg <= short_s | rate_hit | (flag_short_reg & ~en_rise); // RULE_12 RULE_16 RULE_06
            flag_temp_reg <= temp_s | rate_hit | (flag_temp_reg & ~en_rise); // RULE_13 RULE_16 RULE_06
            flag_overv_reg <= overv_s | rate_hit | (flag_overv_reg & ~en_rise); // RULE_14 RULE_16 RULE_06
            flag_lowv_reg <= lowv_s | rate_hit | (flag_lowv_reg & ~en_rise); // RULE_15 RULE_16 RULE_06
            rate_seen_reg <= rate_hit | (rate_seen_reg & ~en_rise);
        end
    end

    // ****************************************************************
    // readiness delay
    // ****************************************************************
    // counts while the axis may run; any fault or disable restarts it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_cnt_reg <= 32'h0000_0000;
            ready_reg <= 1'b0;
        end else if (disabled | any_fault) begin
            ready_cnt_reg <= 32'h0000_0000;
            ready_reg <= 1'b0; // RULE_05 RULE_17
        end else if (ready_cnt_reg < READY_DELAY_CYC - 1) begin
            ready_cnt_reg <= ready_cnt_reg + 32'h0000_0001;
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= 1'b1; // RULE_04 RULE_11
        end
    end

    // ****************************************************************
    // power stage and indicators
    // ****************************************************************
    // phase current follows the inverted current input, so its duty
    // cycle sets the mean current; faults cut it regardless
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            energize_reg <= 1'b0;
            fault_led_reg <= 1'b0;
            temp_led_reg <= 1'b0;
            overv_led_reg <= 1'b0;
            lowv_led_reg <= 1'b0;
        end else begin
            energize_reg <= ~cur_s & ~disabled & ~any_fault; // RULE_09 RULE_10 RULE_17
            fault_led_reg <= flag_short_reg;
            temp_led_reg <= flag_temp_reg;
            overv_led_reg <= flag_overv_reg | disabled; // RULE_05
            lowv_led_reg <= flag_lowv_reg | disabled; // RULE_05
        end
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready_reg;
    wire addr_ok = (paddr == `SSD_OFS_CTRL) | (paddr == `SSD_OFS_STATUS) |
                   (paddr == `SSD_OFS_POSITION) | (paddr == `SSD_OFS_STEPS);

    reg [31:0] rd_mux;

    // read data is chosen in the setup cycle so it can leave a flop
    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `SSD_OFS_CTRL: rd_mux = {20'h00000, ctrl_reg};
            `SSD_OFS_STATUS: begin
                rd_mux[`SSD_ST_READY] = ready_reg;
                rd_mux[`SSD_ST_ENERGIZED] = energize_reg;
                rd_mux[`SSD_ST_MICRO] = micro_mode;
                rd_mux[`SSD_ST_DIR_CCW] = dir_s;
                rd_mux[`SSD_ST_SHORT] = flag_short_reg;
                rd_mux[`SSD_ST_TEMP] = flag_temp_reg;
                rd_mux[`SSD_ST_OVERV] = flag_overv_reg;
                rd_mux[`SSD_ST_LOWV] = flag_lowv_reg;
                rd_mux[`SSD_ST_RATE] = rate_seen_reg;
            end
            `SSD_OFS_POSITION: rd_mux = {18'h00000, ring_reg};
            `SSD_OFS_STEPS: rd_mux = {18'h00000, steps_per_rev};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // one access cycle per transfer, no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready_reg <= 1'b1;
            pslverr_reg <= ~addr_ok;
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
    end

    // switch settings change only at the completing edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `SSD_CTRL_RESET;
        end else if (access_done & pwrite & (paddr == `SSD_OFS_CTRL)) begin
            ctrl_reg <= {pwdata[11:8], 3'b000, pwdata[4:0]};
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ready_relay = ready_reg;
    assign ready_led = ready_reg;
    assign fault_led = fault_led_reg;
    assign temp_led = temp_led_reg;
    assign overv_led = overv_led_reg;
    assign lowv_led = lowv_led_reg;
    assign phase_energize = energize_reg;
    assign phase_current_select = ctrl_reg[`SSD_CTRL_PHCUR_HI:`SSD_CTRL_PHCUR_LO];
    assign current_reduction_switch = ctrl_reg[`SSD_CTRL_IRED_SW];
    assign ring_pos = ring_reg;

endmodule // ssd_axis_ctrl

`default_nettype wire

// ---- rtl/ssd_map.vh ----
`ifndef SSD_MAP_VH
`define SSD_MAP_VH

// ****************************************************************
// register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define SSD_OFS_CTRL 12'h000
`define SSD_OFS_STATUS 12'h004
`define SSD_OFS_POSITION 12'h008
`define SSD_OFS_STEPS 12'h00C

// ****************************************************************
// control register fields
// ****************************************************************
`define SSD_CTRL_GATE_SEL 0
`define SSD_CTRL_MICRO_SW 1
`define SSD_CTRL_STEP_SW1 2
`define SSD_CTRL_STEP_SW2 3
`define SSD_CTRL_IRED_SW 4
`define SSD_CTRL_PHCUR_LO 8
`define SSD_CTRL_PHCUR_HI 11
// factory setting: enable mode, switches off, phase current position 0
`define SSD_CTRL_RESET 12'h000

// ****************************************************************
// status register fields
// ****************************************************************
`define SSD_ST_READY 0
`define SSD_ST_ENERGIZED 1
`define SSD_ST_MICRO 2
`define SSD_ST_DIR_CCW 3
`define SSD_ST_SHORT 4
`define SSD_ST_TEMP 5
`define SSD_ST_OVERV 6
`define SSD_ST_LOWV 7
`define SSD_ST_RATE 8

// ****************************************************************
// steps per revolution
// ****************************************************************
`define SSD_STEPS_200 14'h00C8
`define SSD_STEPS_400 14'h0190
`define SSD_STEPS_500 14'h01F4
`define SSD_STEPS_1000 14'h03E8
`define SSD_MICRO_FACTOR 4'hA

// ****************************************************************
// timing
// ****************************************************************
`define SSD_CLK_PERIOD_NS 10
`define SSD_READY_DELAY_MS 100
`define SSD_READY_DELAY_CYC ((`SSD_READY_DELAY_MS * 1000000) / `SSD_CLK_PERIOD_NS)
`define SSD_MIN_STEP_NS 2000
`define SSD_MIN_STEP_CYC ((`SSD_MIN_STEP_NS + `SSD_CLK_PERIOD_NS - 1) / `SSD_CLK_PERIOD_NS)

`endif

// ---- rtl/ssd_sync.v ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// two-flop synchroniser, one lane per bit
// ****************************************************************
module ssd_sync #(
    parameter WIDTH = 9
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // raw and synchronised levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            reg meta_reg;
            reg stable_reg;
            // first stage feeds only the second stage
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end else begin
                    meta_reg <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate

endmodule // ssd_sync

`default_nettype wire

// ---- sim/ssd_ctl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// motion controller on the step side
// ****
module ssd_ctl_model (
    // clock
    input wire logic pclk,
    // controller outputs
    output logic step_in,
    output logic dir_in,
    output logic cur_ctrl_in
);
    // idle: no step, clockwise, current on
    initial begin
        step_in = 1'b0;
        dir_in = 1'b0;
        cur_ctrl_in = 1'b0;
    end
    // direction settles well ahead of the first edge; pulses are 4 cycles high
    task automatic pulses(input int n, input int gap, input logic d);
        dir_in <= d;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            step_in <= 1'b1;
            repeat (4) @(posedge pclk);
            step_in <= 1'b0;
            repeat (gap - 4) @(posedge pclk);
        end
    endtask
    // static level on the current-off input
    task automatic level(input logic v);
        cur_ctrl_in <= v;
        @(posedge pclk);
    endtask
    // one pwm period, low part first so the share is easy to count
    task automatic pwm(input int lo, input int hi);
        cur_ctrl_in <= 1'b0;
        repeat (lo) @(posedge pclk);
        cur_ctrl_in <= 1'b1;
        repeat (hi) @(posedge pclk);
    endtask
endmodule // ssd_ctl_model
`default_nettype wire

// ---- sim/ssd_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// port checker for one axis
// ****
module ssd_monitor #(
    parameter READY_DELAY_CYC = 20
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // controller and detector inputs
    input wire step_in,
    input wire cur_ctrl_in,
    input wire short_det,
    input wire overtemp_det,
    input wire overvolt_det,
    input wire undervolt_det,
    // readiness, indicators, power stage
    input wire ready_relay,
    input wire ready_led,
    input wire fault_led,
    input wire temp_led,
    input wire overv_led,
    input wire lowv_led,
    input wire phase_energize,
    input wire [13:0] ring_pos
);
    int low_cnt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // run of cycles without readiness, so an early ready shows up
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_cnt <= 0;
        else if (ready_relay)
            low_cnt <= 0;
        else
            low_cnt <= low_cnt + 1;
    end
    chk_ring_cause:
        assert property ($changed(ring_pos) |-> ring_pos == 14'h0000 ||
            ($past(step_in, 3) && !$past(step_in, 4))) else $error("ring moved without step");
    chk_ring_unit:
        assert property ($changed(ring_pos) |-> ring_pos == $past(ring_pos) + 14'h0001 ||
            ring_pos == $past(ring_pos) - 14'h0001 || ring_pos == 14'h0000 ||
            $past(ring_pos) == 14'h0000) else $error("ring jumped");
    chk_cur_off:
        assert property (cur_ctrl_in [*3] |=> !phase_energize) else $error("current not off");
    chk_fault_off:
        assert property (short_det [*5] |=> !phase_energize && !ready_relay)
        else $error("fault left motor on");
    chk_short_flag:
        assert property (short_det [*5] |=> fault_led) else $error("short flag missing");
    chk_temp_flag:
        assert property (overtemp_det [*5] |=> temp_led) else $error("temp flag missing");
    chk_overv_flag:
        assert property (overvolt_det [*5] |=> overv_led) else $error("overv flag missing");
    chk_lowv_flag:
        assert property (undervolt_det [*5] |=> lowv_led) else $error("lowv flag missing");
    chk_ready_pair:
        assert property (ready_led == ready_relay) else $error("ready led and relay differ");
    chk_ready_delay:
        assert property ($rose(ready_relay) |-> low_cnt >= READY_DELAY_CYC - 1)
        else $error("ready too early");
endmodule // ssd_monitor

bind ssd_axis_ctrl ssd_monitor #(.READY_DELAY_CYC(READY_DELAY_CYC)) u_mon (
    .pclk(pclk), .presetn(presetn), .step_in(step_in), .cur_ctrl_in(cur_ctrl_in),
    .short_det(short_det), .overtemp_det(overtemp_det), .overvolt_det(overvolt_det),
    .undervolt_det(undervolt_det), .ready_relay(ready_relay), .ready_led(ready_led),
    .fault_led(fault_led), .temp_led(temp_led), .overv_led(overv_led), .lowv_led(lowv_led),
    .phase_energize(phase_energize), .ring_pos(ring_pos));
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ssd_map.vh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
// ****
// axis control bench
// ****
module testbench;
    localparam int RDY = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic gate_en_in = 1'b0;
    logic fine_res_in = 1'b0;
    logic [3:0] det = 4'h0;
    logic [31:0] rd;
    logic err;
    logic [3:0] cv [4] = '{4'h4, 4'hC, 4'h8, 4'h0};
    logic [31:0] stp [4] = '{32'h000000C8, 32'h00000190, 32'h000001F4, 32'h000003E8};
    int num_errors = 0;
    int n_tests = 0;
    int n;
    wire [31:0] prdata;
    wire pready, pslverr, step_in, dir_in, cur_ctrl_in, ready_relay, ready_led;
    wire fault_led, temp_led, overv_led, lowv_led, phase_energize, current_reduction_switch;
    wire [3:0] phase_current_select;
    wire [13:0] ring_pos;
    wire [3:0] leds = {lowv_led, overv_led, temp_led, fault_led};
    // 100 MHz
    always #5 pclk = ~pclk;
    ssd_ctl_model ctl (.pclk(pclk), .step_in(step_in), .dir_in(dir_in),
        .cur_ctrl_in(cur_ctrl_in));
    ssd_axis_ctrl #(.READY_DELAY_CYC(RDY)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .step_in(step_in),
        .dir_in(dir_in), .gate_en_in(gate_en_in), .fine_res_in(fine_res_in),
        .cur_ctrl_in(cur_ctrl_in), .short_det(det[0]), .overtemp_det(det[1]),
        .overvolt_det(det[2]), .undervolt_det(det[3]), .ready_relay(ready_relay),
        .ready_led(ready_led), .fault_led(fault_led), .temp_led(temp_led),
        .overv_led(overv_led), .lowv_led(lowv_led), .phase_energize(phase_energize),
        .phase_current_select(phase_current_select),
        .current_reduction_switch(current_reduction_switch), .ring_pos(ring_pos));
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // one apb transfer; waits on pready, then an idle cycle so psel never toggles twice
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 50) begin
            t++;
            @(posedge pclk);
        end
        if (t == 50)
            num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // bounded wait for readiness, n holds the cycles taken
    task automatic wait_ready();
        n = 0;
        while (ready_relay !== 1'b1 && n < 200) begin
            n++;
            @(posedge pclk);
        end
        if (ready_relay !== 1'b1)
            num_errors++;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        tick(6);
        `CHK("disabled leds", 4'hC, leds);
        `CHK("disabled ready", 1'b0, ready_relay);
        apb(0, `SSD_OFS_CTRL, 0);
        `CHK("ctrl reset", 32'h00000000, rd);
        apb(0, 12'h010, 0);
        `CHK("unmapped", 1'b1, err);
        // every switch pair against all four fine input and switch combinations
        for (int i = 0; i < 16; i++) begin
            fine_res_in <= i[3];
            apb(1, `SSD_OFS_CTRL, {28'h0000000, cv[i%4]} | (i[2] ? 32'h2 : 32'h0));
            tick(4);
            apb(0, `SSD_OFS_STEPS, 0);
            `CHK("steps", stp[i%4] * ((i[2] ^ i[3]) ? 10 : 1), rd);
        end
        apb(1, `SSD_OFS_CTRL, 32'h00000F10);
        `CHK("phase_current_select", 4'hF, phase_current_select);
        `CHK("current_reduction_switch", 1'b1, current_reduction_switch);
        fine_res_in <= 1'b0;
        apb(1, `SSD_OFS_CTRL, 32'h00000000);
        gate_en_in <= 1'b1;
        @(posedge pclk);
        wait_ready();
        `CHK("ready delay", 1'b1, n >= RDY && n < RDY + 10);
        `CHK("ready_led", 1'b1, ready_led);
        `CHK("enabled leds", 4'h0, leds);
        ctl.pulses(5, 300, 1'b0);
        tick(8);
        `CHK("ring up", 14'h0005, ring_pos);
        ctl.pulses(7, 300, 1'b1);
        tick(8);
        `CHK("ring wrap", 14'h03E6, ring_pos);
        apb(0, `SSD_OFS_POSITION, 0);
        `CHK("position", 32'h000003E6, rd);
        apb(0, `SSD_OFS_STATUS, 0);
        `CHK("dir status", 1'b1, rd[3]);
        apb(1, `SSD_OFS_CTRL, 32'h00000001);
        ctl.pulses(3, 300, 1'b0);
        tick(8);
        `CHK("gated ring", 14'h03E6, ring_pos);
        gate_en_in <= 1'b0;
        ctl.pulses(1, 300, 1'b0);
        tick(8);
        `CHK("open ring", 14'h03E7, ring_pos);
        gate_en_in <= 1'b1;
        apb(1, `SSD_OFS_CTRL, 32'h00000000);
        wait_ready();
        ctl.level(1'b1);
        tick(8);
        `CHK("current off", 1'b0, phase_energize);
        // 20 kHz period at one quarter active: current flows three quarters of it
        n = 0;
        fork
            ctl.pwm(3750, 1250);
            repeat (5010) begin
                @(posedge pclk);
                n += phase_energize;
            end
        join
        `CHK("pwm share", 3750, n);
        ctl.level(1'b0);
        ctl.pulses(2, 50, 1'b0);
        tick(8);
        `CHK("rate leds", 4'hF, leds);
        `CHK("rate ready", 1'b0, ready_relay);
        `CHK("rate energize", 1'b0, phase_energize);
        apb(0, `SSD_OFS_STATUS, 0);
        `CHK("rate status", 9'h1F0, rd[8:0]);
        gate_en_in <= 1'b0;
        tick(8);
        `CHK("held ring", 14'h0000, ring_pos);
        gate_en_in <= 1'b1;
        tick(8);
        `CHK("cleared leds", 4'h0, leds);
        wait_ready();
        `CHK("ready again", 1'b1, ready_relay);
        // each detector alone: flag, latch after the cause is gone, clear by enable
        for (int i = 0; i < 4; i++) begin
            det <= 4'h1 << i;
            tick(8);
            `CHK("det leds", 4'h1 << i, leds);
            `CHK("det ready", 1'b0, ready_relay);
            det <= 4'h0;
            tick(8);
            `CHK("latched leds", 4'h1 << i, leds);
            gate_en_in <= 1'b0;
            tick(8);
            gate_en_in <= 1'b1;
            tick(8);
            `CHK("clear leds", 4'h0, leds);
            wait_ready();
        end
        final_report();
    end
    // the sequence takes about 10.5k cycles
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        final_report();
    end
endmodule // testbench
`default_nettype wire
